// ===== test/ias_far_model.sv
// Purpose: Trigger lines and transfer path beside the sequencer.
// Assumes: H lines per frame; a frame starts at its first line readout.
// Notes: Slow mode lets a transfer outlast the readout.
module ias_far_model #(
    parameter int H = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Control
    input wire logic i_readout,
    input wire logic i_clr,
    input wire logic i_slow,
    // Outputs
    output logic o_xfer_done,
    output logic [4:0] o_trig
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_q;
    int ln, pend, tmr;

    initial o_trig = 5'h0;

    // Trigger k held high for n cycles.
    task drive(input int k, input int n);
        @(posedge i_clk);
        o_trig[k] <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_trig[k] <= 1'b0;
    endtask

    // ----------------------------------------
    // Transfer path
    // ----------------------------------------
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_q <= 1'b0;
            ln <= 0;
            pend <= 0;
            tmr <= 0;
            o_xfer_done <= 1'b0;
        end else begin
            rd_q <= i_readout;
            o_xfer_done <= 1'b0;
            if (i_readout && !rd_q) ln <= (ln == H - 1) ? 0 : ln + 1;
            if (i_clr) ln <= 0;
            tmr <= (pend != 0) ? tmr + 1 : 0;
            if (pend != 0 && tmr == (i_slow ? 20 : 2)) begin
                o_xfer_done <= 1'b1;
                tmr <= 0;
                pend <= pend - 1 + int'(i_readout && !rd_q && ln == 0);
            end else begin
                pend <= pend + int'(i_readout && !rd_q && ln == 0);
            end
        end
    end
endmodule

// ===== test/ias_seq_assertions.sv
// Purpose: Port assertions for the acquisition sequencer.
// Assumes: Bound to every ias_sequencer instance.
// Notes: Start and kill writes are decoded from the bus.
`include "ias_defines.vh"

module ias_seq_checker #(
    parameter CW = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Bus
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire [31:0] o_wb_dat,
    input wire o_wb_ack,
    // Sensor path
    input wire o_exposing_now,
    input wire o_readout,
    input wire o_capture_transferring,
    input wire o_burst_transferring
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire cmd_take = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] &&
        i_wb_adr == `IAS_A_CMD;
    wire begin_take = cmd_take && i_wb_dat[`IAS_K_BEGIN];
    wire kill_take = cmd_take && i_wb_dat[`IAS_K_KILL];
    reg started_reg;
    reg [1:0] kill_age_reg;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            started_reg <= 1'b0;
            kill_age_reg <= 2'h0;
        end else begin
            started_reg <= started_reg | begin_take;
            kill_age_reg <= kill_take ? 2'h3 : kill_age_reg - {1'b0, kill_age_reg != 2'h0};
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_ACK_ONE: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack missing");
    AST_ACK_DROP: assert property (
        o_wb_ack |=> !o_wb_ack) else $error("ack held");
    AST_DAT_IDLE: assert property (
        !o_wb_ack |-> o_wb_dat == 32'h0) else $error("data without ack");
    AST_EXPO_READ: assert property (
        !(o_exposing_now && o_readout)) else $error("exposure overlaps readout");
    AST_EXPO_TO_READ: assert property (
        $fell(o_exposing_now) && kill_age_reg == 2'h0 && !kill_take |-> ##[0:2] o_readout)
        else $error("no readout after exposure");
    AST_NO_EARLY: assert property (
        !started_reg |-> !o_readout && !o_exposing_now) else $error("capture before start");
    AST_KILL: assert property (
        kill_take |-> ##[1:3] (!o_readout && !o_exposing_now)) else $error("kill late");
    AST_XFER_RISE: assert property (
        $rose(o_readout) |-> ##[0:2] o_capture_transferring) else $error("no transfer");
    AST_XFER_OUTLAST: assert property (
        $fell(o_readout) && kill_age_reg == 2'h0 |-> o_capture_transferring)
        else $error("transfer ended with readout");
    AST_BURST_IN_ACQ: assert property (
        o_burst_transferring |-> o_capture_transferring) else $error("burst outside");

    cover property ($rose(o_readout));
    cover property (kill_take);
    cover property ($rose(o_burst_transferring));
endmodule

bind ias_sequencer ias_seq_checker #(.CW(CW)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_exposing_now(o_exposing_now),
    .o_readout(o_readout), .o_capture_transferring(o_capture_transferring),
    .o_burst_transferring(o_burst_transferring));

// ===== test/tb_ias_sequencer.sv
// Purpose: Register level test of the acquisition sequencer.
// Assumes: Arm is issued before every start except the bad mode start.
// Notes: Small sizes and paces keep frames short.
`include "ias_defines.vh"

module tb_ias_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 2;
    logic i_clk, i_rstn, cyc, stb, we, clr, slow;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, q;
    wire [31:0] rdat;
    wire ack, expo, rd, xfer, bxfer, done;
    wire [4:0] trig;
    int miscompares, tests_run, lines, expos, bseen, n, l1;

    ias_sequencer #(.CW(16)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_acq_trig(trig[0]), .i_image_trig(trig[1]), .i_group_begin_trigger(trig[2]),
        .i_group_finish_trigger(trig[3]), .i_group_level_trigger(trig[4]),
        .i_xfer_done(done), .o_exposing_now(expo), .o_readout(rd),
        .o_capture_transferring(xfer), .o_burst_transferring(bxfer));
    ias_far_model #(.H(H)) far (.i_clk(i_clk), .i_rstn(i_rstn), .i_readout(rd),
        .i_clr(clr), .i_slow(slow), .o_xfer_done(done), .o_trig(trig));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge rd) lines++;
    always @(posedge expo) expos++;
    always @(posedge bxfer) bseen++;

    task end_sim;
        $display("mismatches %0d of %0d checks", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k >= 50) chk(0, 1, "no ack");
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d);
    endtask
    task rdr(input logic [7:0] a);
        wb(a, 1'b0, 32'h0);
    endtask
    task go(input logic [31:0] c);
        lines = 0;
        expos = 0;
        wr(`IAS_A_CTRL, c);
        wr(`IAS_A_CMD, 32'h1);
        wr(`IAS_A_CMD, 32'h2);
    endtask
    task wait_idle;
        int k;
        k = 0;
        do begin
            rdr(`IAS_A_STAT);
            k++;
        end while ((q & 32'hc) !== 32'h0 && k < 300);
        chk(q & 32'h7e, 32'h0, "not idle");
    endtask

    initial begin
        {cyc, stb, we, clr, slow} = 5'h0;
        adr = 8'h0;
        sel = 4'hf;
        dat = 32'h0;
        i_rstn = 1'b0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        rdr(`IAS_A_CTRL); chk(q, 32'h2, "ctrl reset");
        rdr(`IAS_A_WIDTH); chk(q, 32'h10, "width reset");
        rdr(8'h30); chk(q, 32'h0, "unmapped");
        far.drive(1, 4); far.drive(0, 4);
        repeat (10) @(posedge i_clk);
        chk(lines, 0, "trigger before start");
        wr(`IAS_A_WIDTH, 4); wr(`IAS_A_HEIGHT, H); wr(`IAS_A_EXPO, 3);
        wr(`IAS_A_FPACE, 4); wr(`IAS_A_LPACE, 4); wr(`IAS_A_MFT, 3); wr(`IAS_A_BLEN, 2);
        wr(`IAS_A_CTRL, 3); wr(`IAS_A_CMD, 32'h2); rdr(`IAS_A_STAT);
        chk(q & 32'h104, 32'h100, "bad mode started");
        slow <= 1'b1;
        go(32'h1); rdr(`IAS_A_STAT); chk(q & 32'h80, 32'h80, "not validated");
        wait_idle; rdr(`IAS_A_FCNT); chk(q, 3, "counted total");
        chk(lines, 3 * H, "lines"); chk(expos, 3, "exposures");
        slow <= 1'b0;
        go(32'h4); wait_idle; rdr(`IAS_A_FCNT); chk(q, 1, "one shot");
        chk(expos, H, "line scan exposures");
        go(32'h2); repeat (150) @(posedge i_clk); wr(`IAS_A_CMD, 32'h4); wait_idle;
        rdr(`IAS_A_FCNT); chk(lines, q * H, "halt cut frame");
        chk(q > 1, 1, "no pacing");
        wr(`IAS_A_SEL, 3); go(32'h8a); far.drive(0, 4); repeat (20) @(posedge i_clk);
        rdr(`IAS_A_STAT); chk(q & 32'h11, 32'h11, "frame wait status");
        wr(`IAS_A_CMD, 32'h4); wait_idle; chk(lines, 0, "pending frame ran");
        go(32'h12); repeat (60) @(posedge i_clk); chk(lines, 0, "burst early");
        far.drive(2, 4); repeat (300) @(posedge i_clk);
        chk(lines, 2 * H, "burst length"); chk(bseen > 0, 1, "burst xfer");
        wr(`IAS_A_CMD, 32'h4); wait_idle;
        go(32'h42); far.drive(4, 60); repeat (40) @(posedge i_clk); l1 = lines;
        repeat (100) @(posedge i_clk); chk(lines, l1, "level low");
        chk(l1 > 0, 1, "level high"); wr(`IAS_A_CMD, 32'h4); wait_idle;
        go(32'h2); n = 0;
        while (rd !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        wr(`IAS_A_CMD, 32'h8); repeat (2) @(posedge i_clk);
        chk({expo, rd}, 0, "kill"); clr <= 1'b1;
        @(posedge i_clk); clr <= 1'b0; wait_idle;
        end_sim;
    end

    initial begin
        #(50ns * 20000);
        miscompares++;
        end_sim;
    end
endmodule

// ===== verilog/ias_defines.vh
// Purpose: Register map and field layout of the acquisition sequencer.
// Assumes: 32-bit classic Wishbone, byte addresses, word aligned.
// Notes: Reset values are the settings after power up.
`ifndef IAS_DEFINES_VH
`define IAS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IAS_A_CTRL 8'h00
`define IAS_A_CMD 8'h04
`define IAS_A_MFT 8'h08
`define IAS_A_BLEN 8'h0c
`define IAS_A_FPACE 8'h10
`define IAS_A_LPACE 8'h14
`define IAS_A_WIDTH 8'h18
`define IAS_A_HEIGHT 8'h1c
`define IAS_A_EXPO 8'h20
`define IAS_A_SEL 8'h24
`define IAS_A_STAT 8'h28
`define IAS_A_FCNT 8'h2c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define IAS_C_MODE 1:0
`define IAS_C_LSCAN 2
`define IAS_C_FTRIG 3
`define IAS_C_GBEGIN 4
`define IAS_C_GFINISH 5
`define IAS_C_GLEVEL 6
`define IAS_C_ATRIG 7
`define IAS_MODE_ONE 2'h0
`define IAS_MODE_COUNTED 2'h1
`define IAS_MODE_CONT 2'h2

// ----------------------------------------
// Command bits
// ----------------------------------------
`define IAS_K_ARM 0
`define IAS_K_BEGIN 1
`define IAS_K_HALT 2
`define IAS_K_KILL 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IAS_R_CTRL 8'h02
`define IAS_R_COUNT 16'h0001
`define IAS_R_FPACE 32'h00004e20
`define IAS_R_LPACE 32'h00000100
`define IAS_R_WIDTH 16'h0010
`define IAS_R_HEIGHT 16'h0004
`define IAS_R_EXPO 32'h00000010

`endif

// ===== verilog/ias_pacer.v
// Purpose: Internal rate timer giving one tick per programmed period.
// Assumes: Period in clock cycles; zero acts as one.
// Notes: Counting restarts whenever run is low.
`include "ias_defines.vh"

module ias_pacer (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Control
    input wire i_run,
    input wire [31:0] i_period,
    // Tick
    output reg o_tick
);

    reg [31:0] cnt_reg;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_reg <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (cnt_reg + 32'h00000001 >= i_period) begin
            cnt_reg <= 32'h00000000;
            o_tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
            o_tick <= 1'b0;
        end
    end

endmodule

// ===== verilog/ias_sequencer.v
// Purpose: Acquisition, burst and frame sequencer with Wishbone registers.
// Assumes: Trigger pins are asynchronous; i_xfer_done is on i_clk.
// Notes: Settings are latched at arm or start and frozen while capturing.
//
// Chosen here: register access over Wishbone and the register offsets.
`include "ias_defines.vh"

// Behaviour
// [R01] Frame is exposure then readout of all lines
// [R02] Transfer may outlast readout, not frame
// [R03] Line-scan exposes and reads every line
// [R04] Acquisition transfer spans first to last frame
// [R05] Burst transfer spans its first to last
// [R06] Burst triggers split acquisition into bursts
// [R07] Begin-only burst captures burst length frames
// [R08] Begin and finish triggers delimit bursts
// [R09] Level trigger captures only while asserted
// [R10] Counted mode captures exact total then ends
// [R11] One-shot one frame; continuous until halt
// [R12] Arm validates and freezes settings
// [R13] Start validates unless already validated
// [R14] Triggers ignored until start issued
// [R15] Halt finishes current frame then ends
// [R16] Halt while waiting cancels pending frame
// [R17] Kill ends capture at once, anytime
// [R18] Untriggered frames paced by frame rate
// [R19] Untriggered lines paced by line rate
// [R20] Selector returns live status signal level
// [R21] After end, return idle, clear activity
module ias_sequencer #(
    parameter CW = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Wishbone slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // Trigger pins
    input wire i_acq_trig,
    input wire i_image_trig,
    input wire i_group_begin_trigger,
    input wire i_group_finish_trigger,
    input wire i_group_level_trigger,
    // Sensor and transfer path
    input wire i_xfer_done,
    output reg o_exposing_now,
    output reg o_readout,
    output reg o_capture_transferring,
    output reg o_burst_transferring
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_IDLE = 6'h01;
    localparam S_WACQ = 6'h02;
    localparam S_WFRM = 6'h04;
    localparam S_WLIN = 6'h08;
    localparam S_EXPO = 6'h10;
    localparam S_READ = 6'h20;

    function last;
        input [CW-1:0] cnt;
        input [CW-1:0] n;
        begin
            last = (cnt + {{(CW-1){1'b0}}, 1'b1} >= n);
        end
    endfunction

    // ----------------------------------------
    // Settings and bus
    // ----------------------------------------
    reg [7:0] ctrl_reg;
    reg [CW-1:0] mft_reg, blen_reg, width_reg, height_reg;
    reg [31:0] fpace_reg, lpace_reg, expo_reg;
    reg [2:0] sel_reg;
    reg [7:0] l_ctrl_reg;
    reg [CW-1:0] l_mft_reg, l_blen_reg, l_width_reg, l_height_reg;
    reg [31:0] l_fpace_reg, l_lpace_reg, l_expo_reg;
    reg valid_reg, err_reg;
    reg [CW-1:0] fcnt_reg;

    wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wr = req & i_wb_we & i_wb_sel[0];
    wire set_wr = wr & (i_wb_adr == `IAS_A_CTRL || i_wb_adr == `IAS_A_MFT ||
        i_wb_adr == `IAS_A_BLEN || i_wb_adr == `IAS_A_FPACE ||
        i_wb_adr == `IAS_A_LPACE || i_wb_adr == `IAS_A_WIDTH ||
        i_wb_adr == `IAS_A_HEIGHT || i_wb_adr == `IAS_A_EXPO);
    wire cmd_wr = wr & (i_wb_adr == `IAS_A_CMD);
    wire c_arm = cmd_wr & i_wb_dat[`IAS_K_ARM];
    wire c_begin = cmd_wr & i_wb_dat[`IAS_K_BEGIN];
    wire c_halt = cmd_wr & i_wb_dat[`IAS_K_HALT];
    wire c_kill = cmd_wr & i_wb_dat[`IAS_K_KILL];
    wire ok = (width_reg != 0) && (height_reg != 0) && (mft_reg != 0) &&
        (blen_reg != 0) && (ctrl_reg[`IAS_C_MODE] != 2'h3);

    reg [5:0] state_reg;
    wire idle = (state_reg == S_IDLE);

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= `IAS_R_CTRL;
            mft_reg <= `IAS_R_COUNT;
            blen_reg <= `IAS_R_COUNT;
            fpace_reg <= `IAS_R_FPACE;
            lpace_reg <= `IAS_R_LPACE;
            width_reg <= `IAS_R_WIDTH;
            height_reg <= `IAS_R_HEIGHT;
            expo_reg <= `IAS_R_EXPO;
            sel_reg <= 3'h0;
        end else if (wr) begin
            case (i_wb_adr)
                `IAS_A_CTRL: ctrl_reg <= i_wb_dat[7:0];
                `IAS_A_MFT: mft_reg <= i_wb_dat[CW-1:0];
                `IAS_A_BLEN: blen_reg <= i_wb_dat[CW-1:0];
                `IAS_A_FPACE: fpace_reg <= i_wb_dat;
                `IAS_A_LPACE: lpace_reg <= i_wb_dat;
                `IAS_A_WIDTH: width_reg <= i_wb_dat[CW-1:0];
                `IAS_A_HEIGHT: height_reg <= i_wb_dat[CW-1:0];
                `IAS_A_EXPO: expo_reg <= i_wb_dat;
                `IAS_A_SEL: sel_reg <= i_wb_dat[2:0];
                default: sel_reg <= sel_reg;
            endcase
        end
    end

    // Validation and freezing of the settings.
    wire do_latch = idle & ok & (c_arm | (c_begin & ~valid_reg)); // see [R12] see [R13]
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            valid_reg <= 1'b0;
            err_reg <= 1'b0;
            l_ctrl_reg <= `IAS_R_CTRL;
            l_mft_reg <= `IAS_R_COUNT;
            l_blen_reg <= `IAS_R_COUNT;
            l_fpace_reg <= `IAS_R_FPACE;
            l_lpace_reg <= `IAS_R_LPACE;
            l_width_reg <= `IAS_R_WIDTH;
            l_height_reg <= `IAS_R_HEIGHT;
            l_expo_reg <= `IAS_R_EXPO;
        end else begin
            if (do_latch) begin
                l_ctrl_reg <= ctrl_reg;
                l_mft_reg <= mft_reg;
                l_blen_reg <= blen_reg;
                l_fpace_reg <= fpace_reg;
                l_lpace_reg <= lpace_reg;
                l_width_reg <= width_reg;
                l_height_reg <= height_reg;
                l_expo_reg <= expo_reg;
            end
            if (set_wr)
                valid_reg <= 1'b0; // see [R13]
            else if (do_latch)
                valid_reg <= 1'b1;
            if (idle & (c_arm | c_begin) & ~valid_reg)
                err_reg <= ~ok;
        end
    end

    // ----------------------------------------
    // Trigger synchronisers
    // ----------------------------------------
    reg [4:0] s1_reg, s2_reg, s3_reg;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            s3_reg <= 5'h00;
        end else begin
            s1_reg <= {i_group_level_trigger, i_group_finish_trigger,
                i_group_begin_trigger, i_image_trig, i_acq_trig};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    wire [4:0] rise = s2_reg & ~s3_reg;
    wire level_on = s2_reg[4];

    // ----------------------------------------
    // Pacing timers
    // ----------------------------------------
    wire ftick, ltick;
    wire trig_off = ~l_ctrl_reg[`IAS_C_FTRIG];
    ias_pacer u_fpace (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_run(~idle & trig_off),
        .i_period(l_fpace_reg),
        .o_tick(ftick)
    );
    ias_pacer u_lpace (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_run(~idle & trig_off),
        .i_period(l_lpace_reg),
        .o_tick(ltick)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    reg [CW-1:0] line_reg, pix_reg, bcnt_reg;
    reg [31:0] ecnt_reg;
    reg halt_reg, burst_reg, fin_reg, fdue_reg;
    reg [7:0] pend_reg;

    wire gb_en = l_ctrl_reg[`IAS_C_GBEGIN];
    wire gf_en = l_ctrl_reg[`IAS_C_GFINISH];
    wire gl_en = l_ctrl_reg[`IAS_C_GLEVEL];
    wire burst_mode = gb_en | gl_en; // see [R06]
    wire burst_open = gl_en ? level_on : burst_reg; // see [R09]
    wire fgo = trig_off ? (fdue_reg | ftick) : rise[1]; // see [R18]
    wire lgo = trig_off ? ltick : 1'b1; // see [R19]
    wire first_exp = l_ctrl_reg[`IAS_C_LSCAN] | (line_reg == 0); // see [R03]
    wire line_end = (state_reg == S_READ) & last(pix_reg, l_width_reg);
    wire frame_end = line_end & last(line_reg, l_height_reg); // see [R01]
    wire [1:0] mode = l_ctrl_reg[`IAS_C_MODE];
    wire count_hit = (mode == `IAS_MODE_ONE) | // see [R11]
        ((mode == `IAS_MODE_COUNTED) & last(fcnt_reg, l_mft_reg)); // see [R10]
    wire bl_hit = gb_en & ~gf_en & ~gl_en & last(bcnt_reg, l_blen_reg); // see [R07]
    wire rd_start = (state_reg != S_READ) & (state_reg != S_IDLE) &
        (state_reg != S_WACQ) & (state_reg != S_WFRM) &
        ((state_reg == S_EXPO) ? (ecnt_reg + 32'h00000001 >= l_expo_reg) :
        (lgo & ~(first_exp & (l_expo_reg != 0))));
    wire pend_dn = i_xfer_done & (pend_reg != 0);

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= S_IDLE;
            line_reg <= {CW{1'b0}};
            pix_reg <= {CW{1'b0}};
            bcnt_reg <= {CW{1'b0}};
            ecnt_reg <= 32'h00000000;
            fcnt_reg <= {CW{1'b0}};
            halt_reg <= 1'b0;
            burst_reg <= 1'b0;
            fin_reg <= 1'b0;
            fdue_reg <= 1'b0;
        end else if (c_kill) begin
            state_reg <= S_IDLE; // see [R17] see [R21]
            burst_reg <= 1'b0;
            halt_reg <= 1'b0;
            fdue_reg <= 1'b0;
        end else begin
            if (ftick & (state_reg != S_WFRM))
                fdue_reg <= 1'b1;
            else if (state_reg == S_WFRM && fgo)
                fdue_reg <= 1'b0;
            if (c_halt & ~idle)
                halt_reg <= 1'b1;
            if (gb_en & gf_en & rise[3] & burst_reg)
                fin_reg <= 1'b1; // see [R08]
            case (state_reg)
                S_IDLE: begin
                    halt_reg <= 1'b0;
                    fin_reg <= 1'b0;
                    burst_reg <= 1'b0;
                    fdue_reg <= 1'b0;
                    if (c_begin)
                        fcnt_reg <= {CW{1'b0}};
                    if (c_begin & (valid_reg | ok))
                        state_reg <= l_ctrl_reg[`IAS_C_ATRIG] & valid_reg ? S_WACQ :
                            (ctrl_reg[`IAS_C_ATRIG] ? S_WACQ : S_WFRM);
                end
                S_WACQ: begin
                    if (c_halt)
                        state_reg <= S_IDLE; // see [R16]
                    else if (rise[0])
                        state_reg <= S_WFRM; // see [R14]
                end
                S_WFRM: begin
                    if (c_halt | halt_reg)
                        state_reg <= S_IDLE; // see [R16]
                    else if (burst_mode & ~gl_en & ~burst_reg) begin
                        if (rise[2]) begin
                            burst_reg <= 1'b1;
                            bcnt_reg <= {CW{1'b0}};
                        end
                    end else if (fin_reg) begin
                        burst_reg <= 1'b0;
                        fin_reg <= 1'b0;
                    end else if (fgo & (~burst_mode | burst_open)) begin
                        line_reg <= {CW{1'b0}};
                        state_reg <= S_WLIN;
                    end
                end
                S_WLIN: begin
                    ecnt_reg <= 32'h00000000;
                    pix_reg <= {CW{1'b0}};
                    if (rd_start)
                        state_reg <= S_READ;
                    else if (lgo)
                        state_reg <= S_EXPO;
                end
                S_EXPO: begin
                    ecnt_reg <= ecnt_reg + 32'h00000001;
                    if (rd_start)
                        state_reg <= S_READ;
                end
                S_READ: begin
                    pix_reg <= pix_reg + {{(CW-1){1'b0}}, 1'b1};
                    if (frame_end) begin
                        fcnt_reg <= fcnt_reg + {{(CW-1){1'b0}}, 1'b1};
                        bcnt_reg <= bcnt_reg + {{(CW-1){1'b0}}, 1'b1};
                        if (bl_hit)
                            burst_reg <= 1'b0;
                        if (halt_reg | c_halt | count_hit)
                            state_reg <= S_IDLE; // see [R15] see [R21]
                        else
                            state_reg <= S_WFRM;
                    end else if (line_end) begin
                        line_reg <= line_reg + {{(CW-1){1'b0}}, 1'b1};
                        state_reg <= S_WLIN;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Transfer tracking
    // ----------------------------------------
    wire rd_begin = rd_start & (line_reg == 0) & ~c_kill;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_reg <= 8'h00;
            o_capture_transferring <= 1'b0;
            o_burst_transferring <= 1'b0;
        end else if (c_kill) begin
            pend_reg <= 8'h00;
            o_capture_transferring <= 1'b0; // see [R21]
            o_burst_transferring <= 1'b0;
        end else begin
            // Transfer starts with readout and ends apart from the frame.
            pend_reg <= pend_reg + {7'h00, rd_begin} - {7'h00, pend_dn}; // see [R02]
            if (rd_begin)
                o_capture_transferring <= 1'b1; // see [R04]
            else if (idle & (pend_reg == 0))
                o_capture_transferring <= 1'b0; // see [R04]
            if (rd_begin & burst_mode)
                o_burst_transferring <= 1'b1; // see [R05]
            else if ((idle | ~burst_open) & (pend_reg == 0))
                o_burst_transferring <= 1'b0; // see [R05]
        end
    end

    // ----------------------------------------
    // Status and readback
    // ----------------------------------------
    wire [5:0] stat = {state_reg == S_EXPO,
        (state_reg == S_WLIN) | (state_reg == S_EXPO) | (state_reg == S_READ),
        state_reg == S_WFRM, o_capture_transferring,
        ~idle & (state_reg != S_WACQ), state_reg == S_WACQ};
    reg [31:0] rd;
    always @* begin
        case (i_wb_adr)
            `IAS_A_CTRL: rd = {24'h000000, ctrl_reg};
            `IAS_A_MFT: rd = {{(32-CW){1'b0}}, mft_reg};
            `IAS_A_BLEN: rd = {{(32-CW){1'b0}}, blen_reg};
            `IAS_A_FPACE: rd = fpace_reg;
            `IAS_A_LPACE: rd = lpace_reg;
            `IAS_A_WIDTH: rd = {{(32-CW){1'b0}}, width_reg};
            `IAS_A_HEIGHT: rd = {{(32-CW){1'b0}}, height_reg};
            `IAS_A_EXPO: rd = expo_reg;
            `IAS_A_SEL: rd = {29'h00000000, sel_reg};
            `IAS_A_STAT: rd = {23'h000000, err_reg, valid_reg, stat,
                (sel_reg < 3'h6) ? stat[sel_reg] : 1'b0}; // see [R20]
            `IAS_A_FCNT: rd = {{(32-CW){1'b0}}, fcnt_reg};
            default: rd = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
            o_exposing_now <= 1'b0;
            o_readout <= 1'b0;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= req ? rd : 32'h00000000;
            o_exposing_now <= (state_reg == S_EXPO) & ~c_kill & ~rd_start;
            o_readout <= ((state_reg == S_READ) & ~line_end | rd_start) & ~c_kill;
        end
    end

endmodule
